// ==== common/tmr16_pkg.sv ====
// package for the 16-bit timer register block: offsets, fields, resets
// assumes byte-wide register port of the core, one clock domain
package tmr16_pkg;
  // register offsets on the data-space byte port
  localparam logic [7:0] TMR16_IMSK_ADDR = 8'h6f;
  localparam logic [7:0] TMR16_CNTL_ADDR = 8'h84;
  localparam logic [7:0] TMR16_CNTH_ADDR = 8'h85;
  localparam logic [7:0] TMR16_CAPL_ADDR = 8'h86;
  localparam logic [7:0] TMR16_CAPH_ADDR = 8'h87;
  localparam logic [7:0] TMR16_CMAL_ADDR = 8'h88;
  localparam logic [7:0] TMR16_CMAH_ADDR = 8'h89;
  localparam logic [7:0] TMR16_CMBL_ADDR = 8'h8a;
  localparam logic [7:0] TMR16_CMBH_ADDR = 8'h8b;
  localparam logic [7:0] TMR16_FLAG_ADDR = 8'h36;
  // flag and mask bit positions (same in both registers)
  localparam int TMR16_BIT_OVF = 0;
  localparam int TMR16_BIT_CMA = 1;
  localparam int TMR16_BIT_CMB = 2;
  localparam int TMR16_BIT_CAP = 5;
  localparam logic [7:0] TMR16_IMSK_WMASK = 8'h27;
  // reset values and the full-range top
  localparam logic [7:0]  TMR16_BYTE_RST = 8'h00;
  localparam logic [15:0] TMR16_WORD_RST = 16'h0000;
  localparam logic [15:0] TMR16_WORD_MAX = 16'hffff;
endpackage

// ==== rtl/tmr16_sync.sv ====
// two flip-flop synchroniser for the pin inputs of the timer
// assumes inputs are asynchronous to core_clk_i
`timescale 1ns/1ps
`default_nettype none
module tmr16_sync
(
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  input  wire logic async_i,
  output var  logic sync_o
);
  logic meta_reg;   // first stage, read only by second
  logic meta_next;
  logic sync_reg;   // second stage, safe to use
  logic sync_next;

  // next values: plain shift
  always_comb
  begin
    meta_next = async_i;
    sync_next = meta_reg;
  end

  // register stages, synchronous reset
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end
    else
    begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_o = sync_reg;
endmodule
`default_nettype wire

// ==== rtl/tmr16_regs.sv ====
// register block of a 16-bit timer: counter, capture, two compares,
// interrupt mask, flags and the shared high-byte latch
// assumes the core gives one-cycle rd/wr strobes with byte address;
// read data is registered and valid the cycle after the read strobe
//
// Summary of operation
// R1 - counter readable and writable as two bytes
// R2 - counter bytes pass the high-byte latch
// R3 - one latch shared by all word registers
// R4 - counter write blocks next compare match
// R5 - software avoids changing a running counter
// R6 - capture event copies counter to capture
// R7 - capture source selectable: pin or comparator
// R8 - capture value may serve as top
// R9 - capture reads pass the shared latch
// R10 - compares checked against counter every tick
// R11 - match raises flag and drives output
// R12 - compare writes pass the shared latch
// R13 - match flag set tick after equality
// R14 - flags clear on vector or one-write
// R15 - request needs mask, global enable, flag
// R16 - counter/capture low read latches high; low write commits
// R17 - all registers reset to zero
`timescale 1ns/1ps
`default_nettype none
module tmr16_regs
(
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] addr_i,       // byte register address
  input  wire logic [7:0] wdata_i,      // write data
  input  wire logic       wr_i,         // one-cycle write strobe
  input  wire logic       rd_i,         // one-cycle read strobe
  output var  logic [7:0] rdata_o,      // registered read data
  input  wire logic       tick_i,       // timer clock enable
  input  wire logic       top_cap_i,    // top taken from capture value
  input  wire logic       cap_sel_i,    // 1: comparator is capture src
  input  wire logic       capture_input_pin_i,
  input  wire logic       comparator_i,
  input  wire logic       global_ie_i,  // core global interrupt enable
  input  wire logic [3:0] vec_ack_i,    // cap, cmb, cma, ovf vectors
  output var  logic [3:0] irq_o,        // cap, cmb, cma, ovf requests
  output var  logic [1:0] compare_output_pin_o  // toggles on match b,a
);
  ////////////////////////////////////////////////////////////////////
  // state
  logic [15:0] counter_value_reg,  counter_value_next;
  logic [15:0] capture_value_reg,  capture_value_next;
  logic [15:0] compare_a_value_reg, compare_a_value_next;
  logic [15:0] compare_b_value_reg, compare_b_value_next;
  logic [7:0]  temp_reg,  temp_next;     // shared high-byte latch
  logic [7:0]  imsk_reg,  imsk_next;     // interrupt enable mask
  logic [7:0]  flag_reg,  flag_next;     // sticky flags
  logic        block_reg, block_next;    // match blocked next tick
  logic [1:0]  ocp_reg,   ocp_next;      // compare output pins
  logic [3:0]  irq_reg,   irq_next;
  logic [7:0]  rdata_reg, rdata_next;
  logic        src_prev_reg, src_prev_next;  // edge detect history
  logic        pin_s, cmp_s;             // synchronised sources
  logic [15:0] top_w;
  logic        cap_evt, ma, mb, ovf_evt;
  logic        wr_cnt;
  logic [7:0]  pend_w;                   // flag and mask both set

  ////////////////////////////////////////////////////////////////////
  // pin synchronisers: both sources come from outside the clock
  tmr16_sync u_sync_pin
  (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .async_i    (capture_input_pin_i),
    .sync_o     (pin_s)
  );
  tmr16_sync u_sync_cmp
  (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .async_i    (comparator_i),
    .sync_o     (cmp_s)
  );

  // assemble word write: latch high byte, low write commits
  function automatic logic [15:0] word_wr(input logic [7:0] hi,
                                          input logic [7:0] lo);
    word_wr = {hi, lo};
  endfunction

  ////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb
  begin
    counter_value_next   = counter_value_reg;
    capture_value_next   = capture_value_reg;
    compare_a_value_next = compare_a_value_reg;
    compare_b_value_next = compare_b_value_reg;
    temp_next    = temp_reg;
    imsk_next    = imsk_reg;
    flag_next    = flag_reg;
    block_next   = block_reg;
    ocp_next     = ocp_reg;
    rdata_next   = 8'h00;
    wr_cnt       = wr_i && (addr_i == tmr16_pkg::TMR16_CNTL_ADDR);
    // capture value as top when selected, else full range
    top_w = top_cap_i ? capture_value_reg                      // R8
                      : tmr16_pkg::TMR16_WORD_MAX;
    // rising edge of chosen source; either source disconnected when capture is top
    src_prev_next = cap_sel_i ? cmp_s : pin_s;                 // R7
    cap_evt = src_prev_next && !src_prev_reg && !top_cap_i;
    // compare equality, suppressed on the tick after a counter write
    ma = tick_i && !block_reg                                  // R4
         && (counter_value_reg == compare_a_value_reg);        // R10
    mb = tick_i && !block_reg
         && (counter_value_reg == compare_b_value_reg);
    ovf_evt = tick_i && (counter_value_reg == top_w);
    // counter advance on tick, wraps at top
    if (tick_i)
    begin
      counter_value_next = (counter_value_reg == top_w)
                           ? tmr16_pkg::TMR16_WORD_RST
                           : 16'(counter_value_reg + 16'h0001);
      block_next = 1'b0;
    end
    if (cap_evt)
      capture_value_next = counter_value_reg;                  // R6
    // vector acknowledges clear flags
    flag_next[tmr16_pkg::TMR16_BIT_OVF] &= !vec_ack_i[0];      // R14
    flag_next[tmr16_pkg::TMR16_BIT_CMA] &= !vec_ack_i[1];
    flag_next[tmr16_pkg::TMR16_BIT_CMB] &= !vec_ack_i[2];
    flag_next[tmr16_pkg::TMR16_BIT_CAP] &= !vec_ack_i[3];
    // register writes
    if (wr_i)
    begin
      case (addr_i)
        tmr16_pkg::TMR16_IMSK_ADDR:
          imsk_next = wdata_i & tmr16_pkg::TMR16_IMSK_WMASK;
        tmr16_pkg::TMR16_FLAG_ADDR:
          flag_next = flag_next & ~(wdata_i                    // R14
                      & tmr16_pkg::TMR16_IMSK_WMASK);
        tmr16_pkg::TMR16_CNTH_ADDR,
        tmr16_pkg::TMR16_CAPH_ADDR,
        tmr16_pkg::TMR16_CMAH_ADDR,
        tmr16_pkg::TMR16_CMBH_ADDR:
          temp_next = wdata_i;                                 // R3 R16
        tmr16_pkg::TMR16_CNTL_ADDR:
        begin
          counter_value_next = word_wr(temp_reg, wdata_i);     // R1 R2
          block_next = 1'b1;                                   // R4
        end
        tmr16_pkg::TMR16_CAPL_ADDR:
          capture_value_next = word_wr(temp_reg, wdata_i);
        tmr16_pkg::TMR16_CMAL_ADDR:
          compare_a_value_next = word_wr(temp_reg, wdata_i);   // R12
        tmr16_pkg::TMR16_CMBL_ADDR:
          compare_b_value_next = word_wr(temp_reg, wdata_i);   // R12
        default: ;                                   // unmapped ignored
      endcase
    end
    // hardware sets win over any clear in the same cycle
    if (ovf_evt) flag_next[tmr16_pkg::TMR16_BIT_OVF] = 1'b1;
    if (ma)      flag_next[tmr16_pkg::TMR16_BIT_CMA] = 1'b1;   // R13
    if (mb)      flag_next[tmr16_pkg::TMR16_BIT_CMB] = 1'b1;   // R13
    if (cap_evt) flag_next[tmr16_pkg::TMR16_BIT_CAP] = 1'b1;
    // match toggles the channel output pin
    ocp_next = ocp_reg ^ {mb, ma};                             // R11
    // reads: counter or capture low read snapshots high byte into the latch
    if (rd_i)
    begin
      case (addr_i)
        tmr16_pkg::TMR16_IMSK_ADDR: rdata_next = imsk_reg;
        tmr16_pkg::TMR16_FLAG_ADDR: rdata_next = flag_reg;
        tmr16_pkg::TMR16_CNTL_ADDR:
        begin
          rdata_next = counter_value_reg[7:0];                 // R1
          temp_next  = counter_value_reg[15:8];                // R2 R16
        end
        tmr16_pkg::TMR16_CAPL_ADDR:
        begin
          rdata_next = capture_value_reg[7:0];
          temp_next  = capture_value_reg[15:8];                // R9
        end
        tmr16_pkg::TMR16_CMAL_ADDR: rdata_next = compare_a_value_reg[7:0];
        tmr16_pkg::TMR16_CMBL_ADDR: rdata_next = compare_b_value_reg[7:0];
        // compare high bytes are not latched, read direct
        tmr16_pkg::TMR16_CMAH_ADDR: rdata_next = compare_a_value_reg[15:8];
        tmr16_pkg::TMR16_CMBH_ADDR: rdata_next = compare_b_value_reg[15:8];
        tmr16_pkg::TMR16_CNTH_ADDR,
        tmr16_pkg::TMR16_CAPH_ADDR: rdata_next = temp_reg;     // R3
        default:                    rdata_next = 8'h00;  // unmapped: zero
      endcase
    end
    // requests gated by mask, global enable and flag
    pend_w   = flag_reg & imsk_reg;
    irq_next = {pend_w[tmr16_pkg::TMR16_BIT_CAP],
                pend_w[tmr16_pkg::TMR16_BIT_CMB],
                pend_w[tmr16_pkg::TMR16_BIT_CMA],
                pend_w[tmr16_pkg::TMR16_BIT_OVF]}
               & {4{global_ie_i}};                             // R15
  end

  ////////////////////////////////////////////////////////////////////
  // registers, all return to zero on reset
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      counter_value_reg   <= tmr16_pkg::TMR16_WORD_RST;        // R17
      capture_value_reg   <= tmr16_pkg::TMR16_WORD_RST;
      compare_a_value_reg <= tmr16_pkg::TMR16_WORD_RST;
      compare_b_value_reg <= tmr16_pkg::TMR16_WORD_RST;
      temp_reg     <= tmr16_pkg::TMR16_BYTE_RST;
      imsk_reg     <= tmr16_pkg::TMR16_BYTE_RST;
      flag_reg     <= tmr16_pkg::TMR16_BYTE_RST;
      rdata_reg    <= tmr16_pkg::TMR16_BYTE_RST;
      block_reg    <= 1'b0;
      ocp_reg      <= 2'b00;
      irq_reg      <= 4'h0;
      src_prev_reg <= 1'b0;
    end
    else
    begin
      counter_value_reg   <= counter_value_next;
      capture_value_reg   <= capture_value_next;
      compare_a_value_reg <= compare_a_value_next;
      compare_b_value_reg <= compare_b_value_next;
      temp_reg     <= temp_next;
      imsk_reg     <= imsk_next;
      flag_reg     <= flag_next;
      rdata_reg    <= rdata_next;
      block_reg    <= block_next;
      ocp_reg      <= ocp_next;
      irq_reg      <= irq_next;
      src_prev_reg <= src_prev_next;
    end
  end

  assign rdata_o = rdata_reg;
  assign irq_o   = irq_reg;
  assign compare_output_pin_o = ocp_reg;

  ////////////////////////////////////////////////////////////////////
  // checks
  // single-strobe forms: the core never needs back-to-back accesses
  AST_CNT_WRITE: assert property (@(posedge core_clk_i)  // R2
    disable iff (rst_i)
    wr_cnt && !tick_i |=> counter_value_reg == $past({temp_reg, wdata_i}))
    else $error("counter write not committed");
  AST_BLOCK: assert property (@(posedge core_clk_i)  // R4
    disable iff (rst_i)
    wr_cnt |=> !ma && !mb)
    else $error("match not blocked after counter write");
  AST_CAPTURE: assert property (@(posedge core_clk_i)  // R6
    disable iff (rst_i)
    cap_evt && !(wr_i && addr_i == tmr16_pkg::TMR16_CAPL_ADDR)
    |=> capture_value_reg == $past(counter_value_reg))
    else $error("capture value wrong");
  AST_CAP_LATCH: assert property (@(posedge core_clk_i)  // R9
    disable iff (rst_i)
    rd_i && addr_i == tmr16_pkg::TMR16_CAPL_ADDR
    |=> temp_reg == $past(capture_value_reg[15:8]))
    else $error("capture high byte not latched");
  AST_HI_READ: assert property (@(posedge core_clk_i)  // R16
    disable iff (rst_i)
    rd_i && (addr_i == tmr16_pkg::TMR16_CNTH_ADDR
             || addr_i == tmr16_pkg::TMR16_CAPH_ADDR)
    |=> rdata_o == $past(temp_reg))
    else $error("high byte read not from latch");
  AST_CMP_WRITE: assert property (@(posedge core_clk_i)  // R12
    disable iff (rst_i)
    wr_i && addr_i == tmr16_pkg::TMR16_CMAL_ADDR
    |=> compare_a_value_reg == $past({temp_reg, wdata_i}))
    else $error("compare word not committed");
  AST_MATCH_FLAG: assert property (@(posedge core_clk_i)  // R13
    disable iff (rst_i)
    mb |=> flag_reg[tmr16_pkg::TMR16_BIT_CMB])
    else $error("compare b flag not set");
  AST_FLAG_CLR: assert property (@(posedge core_clk_i)  // R14
    disable iff (rst_i)
    wr_i && addr_i == tmr16_pkg::TMR16_FLAG_ADDR
    && wdata_i[tmr16_pkg::TMR16_BIT_CAP] && !cap_evt
    |=> !flag_reg[tmr16_pkg::TMR16_BIT_CAP])
    else $error("flag not cleared by one-write");
  AST_IRQ: assert property (@(posedge core_clk_i)  // R15
    disable iff (rst_i)
    irq_o[1] |-> $past(global_ie_i) && $past(imsk_reg[1]))
    else $error("request without enable");
  AST_PIN: assert property (@(posedge core_clk_i)  // R11
    disable iff (rst_i)
    ma |=> compare_output_pin_o[0] != $past(compare_output_pin_o[0]))
    else $error("output pin not toggled");
  COV_MATCH: cover property (@(posedge core_clk_i) ma);
  COV_CAP:   cover property (@(posedge core_clk_i) cap_evt);
  COV_IRQ:   cover property (@(posedge core_clk_i) irq_o[3]);
endmodule
`default_nettype wire

// ==== testbench/tmr16_core_model.sv ====
// core-side model: byte master of the timer register block
// assumes the bench calls its tasks; all driving at falling edges
`timescale 1ns/1ps
`default_nettype none
module tmr16_core_model
(
  input  wire logic       core_clk_i,
  input  wire logic [7:0] rdata_i,
  output var  logic [7:0] addr_o,
  output var  logic [7:0] wdata_o,
  output var  logic       wr_o,
  output var  logic       rd_o
);
  // idle bus at time zero
  initial
  begin
    addr_o = 8'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  // one strobe across exactly one rising edge, then release
  task automatic access(input logic w, input logic [7:0] a,
                        input logic [7:0] d, output logic [7:0] q);
    @(negedge core_clk_i);
    addr_o = a;
    wdata_o = d;
    wr_o = w;
    rd_o = !w;
    @(negedge core_clk_i);
    q = rdata_i;            // registered data stands this cycle
    wr_o = 1'b0;
    rd_o = 1'b0;
    // released bus shows the inverse so stale values never pass
    addr_o = ~a;
    wdata_o = ~d;
  endtask
  // single byte write
  task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    access(1'b1, a, d, q);
  endtask
  // single byte read
  task automatic rd_byte(input logic [7:0] a, output logic [7:0] q);
    access(1'b0, a, 8'h00, q);
  endtask
  // word write: high byte first so the low write commits both
  task automatic wr_word(input logic [7:0] lo_a, input logic [15:0] v);
    wr_byte(lo_a + 8'h01, v[15:8]);
    wr_byte(lo_a, v[7:0]);
  endtask
endmodule
`default_nettype wire

// ==== testbench/tmr16_regs_tb.sv ====
// self-checking bench for the timer register block
// assumes the core model as bus master, one 25 MHz clock
`timescale 1ns/1ps
`default_nettype none
module tmr16_regs_tb;
  logic       core_clk_i;  // 40 ns clock
  logic       rst_i;       // sync reset, high
  logic [7:0] addr, wdata, rdata;
  logic       wr, rd;
  logic       tick, top_cap, cap_sel, pin, comp, gie;
  logic [3:0] vec_ack;     // {cap,cmb,cma,ovf} vector taken
  logic [3:0] irq;
  logic [1:0] cmp_pin;     // {b,a} compare outputs
  int         err_total;
  int         compares;
  logic [7:0] q;
  tmr16_regs dut_u (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .tick_i(tick), .top_cap_i(top_cap), .cap_sel_i(cap_sel),
    .capture_input_pin_i(pin), .comparator_i(comp), .global_ie_i(gie),
    .vec_ack_i(vec_ack), .irq_o(irq), .compare_output_pin_o(cmp_pin));
  tmr16_core_model core_u (.core_clk_i(core_clk_i), .rdata_i(rdata),
    .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
  // free running clock
  initial
  begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end
  ////////////////////////////////////////////////////////////////////////
  // verdict, the single end of the run
  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // compare seen against expected, count both
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // read a register and compare
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    core_u.rd_byte(a, q);
    check(q, exp);
  endtask
  // one timer tick; counter is only written while no tick runs
  task automatic tick1();
    @(negedge core_clk_i);
    tick = 1'b1;
    @(negedge core_clk_i);
    tick = 1'b0;
  endtask
  // fixed settle time for pin synchroniser and flag pipeline
  task automatic idle(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask
  // bounded wait for an interrupt request line
  task automatic wait_irq(input int b);
    int n;
    n = 0;
    while (irq[b] !== 1'b1 && n < 8)
    begin
      @(negedge core_clk_i);
      n++;
    end
    if (irq[b] !== 1'b1)
    begin
      err_total++;
      $display("FAIL t=%0t interrupt request never rose", $time);
      final_report();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  // reset values, unmapped read, mask bits that do not exist
  task automatic t_reset();
    logic [7:0] regs [10];
    regs = '{8'h6f, 8'h84, 8'h85, 8'h86, 8'h87, 8'h88, 8'h89, 8'h8a,
             8'h8b, 8'h36};
    foreach (regs[i]) rdchk(regs[i], 8'h00);
    rdchk(8'h00, 8'h00);
    core_u.wr_byte(8'h6f, 8'hff);
    rdchk(8'h6f, tmr16_pkg::TMR16_IMSK_WMASK);
    $display("test reset done");
  endtask
  // counter word write and atomic read, then the shared latch
  task automatic t_words();
    core_u.wr_word(8'h84, 16'h1234);
    rdchk(8'h84, 8'h34);
    rdchk(8'h85, 8'h12);
    core_u.wr_byte(8'h89, 8'hab);
    core_u.wr_byte(8'h84, 8'h55);
    rdchk(8'h84, 8'h55);
    rdchk(8'h85, 8'hab);
    core_u.wr_byte(8'h88, 8'hcd);
    rdchk(8'h89, 8'hab);
    rdchk(8'h88, 8'hcd);
    $display("test words done");
  endtask
  // compare a match: flag, pin, request gating, vector clear
  task automatic t_match();
    core_u.wr_word(8'h88, 16'h0020);
    core_u.wr_word(8'h84, 16'h001e);
    core_u.wr_byte(8'h6f, 8'h02);
    gie = 1'b1;
    repeat (3) tick1();
    wait_irq(tmr16_pkg::TMR16_BIT_CMA);
    check({7'h00, cmp_pin[0]}, 8'h01);
    rdchk(8'h36, 8'h02);
    gie = 1'b0;
    idle(2);
    check({4'h0, irq}, 8'h00);
    vec_ack = 4'h2;
    idle(1);
    vec_ack = 4'h0;
    idle(2);
    rdchk(8'h36, 8'h00);
    $display("test match done");
  endtask
  // counter write lands on the compare b value: match suppressed
  task automatic t_block();
    core_u.wr_word(8'h8a, 16'h0040);
    rdchk(8'h8a, 8'h40);
    core_u.wr_word(8'h84, 16'h0040);
    repeat (2) tick1();
    idle(4);
    rdchk(8'h36, 8'h00);
    check({7'h00, cmp_pin[1]}, 8'h00);
    // one below: the blocked tick steps onto the value, next one matches
    core_u.wr_word(8'h84, 16'h003f);
    repeat (2) tick1();
    rdchk(8'h36, 8'h04);
    check({7'h00, cmp_pin[1]}, 8'h01);
    core_u.wr_byte(8'h36, 8'h04);
    rdchk(8'h36, 8'h00);
    $display("test block done");
  endtask
  // capture from pin, then from comparator, then capture as top
  task automatic t_capture();
    core_u.wr_word(8'h84, 16'h0234);
    pin = 1'b1;
    idle(6);
    rdchk(8'h86, 8'h34);
    rdchk(8'h87, 8'h02);
    rdchk(8'h36, 8'h20);
    cap_sel = 1'b1;
    core_u.wr_word(8'h84, 16'h0567);
    comp = 1'b1;
    idle(6);
    rdchk(8'h86, 8'h67);
    rdchk(8'h87, 8'h05);
    top_cap = 1'b1;
    tick1();
    idle(2);
    rdchk(8'h84, 8'h00);
    rdchk(8'h85, 8'h00);
    rdchk(8'h36, 8'h21);
    // both pending flags reach the request lines once enabled
    core_u.wr_byte(8'h6f, 8'h21);
    gie = 1'b1;
    idle(2);
    check({4'h0, irq}, 8'h09);
    core_u.wr_byte(8'h36, 8'h21);
    rdchk(8'h36, 8'h00);
    $display("test capture done");
  endtask
  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    err_total = 0;
    compares = 0;
    rst_i = 1'b1;
    {tick, top_cap, cap_sel, pin, comp, gie} = 6'h00;
    vec_ack = 4'h0;
    repeat (4) @(negedge core_clk_i);
    rst_i = 1'b0;
    t_reset();
    t_words();
    t_match();
    t_block();
    t_capture();
    final_report();
  end
endmodule
`default_nettype wire
